// File: hdlc_defines.svh
`ifndef HDLC_DEFINES_SVH
`define HDLC_DEFINES_SVH

// Host port register addresses
`define ADDR_EVENT_STATUS 8'hB1
`define ADDR_EVENT_MASK   8'hB2
`define ADDR_RX_INFO      8'hB3
`define ADDR_RX_FIFO      8'hB4

// Event register bit positions
`define EV_RX_END   6
`define EV_RX_START 5
`define EV_RX_HALF  4
`define EV_RX_NE    3
`define EV_TX_HALF  2
`define EV_TX_NF    1
`define EV_TX_MEND  0
`define EV_LATCHED  7'h61
`define EV_WIDTH    7

// Receive information bit positions
`define INF_ABORT  7
`define INF_CRCERR 6
`define INF_OVR    5
`define INF_VALID  4
`define INF_EMPTY  3
`define INF_GOOD   2
`define INF_CLOSE  1
`define INF_OPEN   0

// Sizes and reset values
`define FIFO_DEPTH  64
`define ABORT_ONES  3'h7
`define ONES_PRE    3'h6
`define ZERO8       8'h00
`define MASK_RESET  8'h00

`endif

// File: hdlc_pkg.sv
package hdlc_pkg;

    // One received byte with its framing marks
    typedef struct packed {
        logic       first;
        logic       last;
        logic       crc_ok;
        logic [7:0] data;
    } rx_byte_t;

    // One stored FIFO entry with head-of-FIFO tags
    typedef struct packed {
        logic       first;
        logic       last;
        logic       good;
        logic [7:0] data;
    } fifo_entry_t;

    // One host port access
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } host_req_t;

    // Receive message tracking
    typedef enum logic [1:0] {
        MSG_IDLE  = 2'b00,
        MSG_BODY  = 2'b01,
        MSG_FAULT = 2'b10
    } msg_state_t;

endpackage

// File: rx_fifo_mem.sv
`timescale 1ns/100ps

module rx_fifo_mem #(
    parameter int WIDTH = 11,
    parameter int DEPTH = 64,
    parameter int AW    = $clog2(DEPTH)
) (
    // Clock
    input  wire logic             ref_clk,
    // Write side
    input  wire logic             wr_en,
    input  wire logic [AW-1:0]    wr_addr,
    input  wire logic [WIDTH-1:0] wr_data,
    // Read side
    input  wire logic [AW-1:0]    rd_addr,
    output logic      [WIDTH-1:0] rd_data
);

    logic [WIDTH-1:0] mem [DEPTH];

    // Storage write
    always_ff @(posedge ref_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // Registered read of the addressed entry
    always_ff @(posedge ref_clk) begin
        rd_data <= mem[rd_addr];
    end

endmodule

// File: hdlc_rx_status_and_event_unit.sv
`timescale 1ns/100ps
`include "hdlc_defines.svh"
// Function
// - Packet end on good finish or fault
// - Packet start on opening byte
// - Receive half-full above FIFO midpoint
// - Receive not-empty while bytes wait
// - Transmit half-empty below FIFO midpoint
// - Transmit not-full while room remains
// - Transmit message end on finished message
// - Start, end, tx-end latched until a written one clears them
// - Per-event mask bit gates interrupt
// - Abort flag on seven ones
// - Checksum error flag on bad CRC
// - Overrun flag on store into full
// - Valid flag on checked good packet
// - Live empty level for receive FIFO
// - Good tag on last byte of good message
// - Closing tag on any last byte
// - Opening tag on first byte
// - Info flags latched until a written one clears them
// - FIFO byte presented MSB in bit 7
// - Low interrupt while unmasked event pending
// - Written ones load copy and clear latch
module hdlc_rx_status_and_event_unit #(
    parameter int DEPTH = `FIFO_DEPTH,
    parameter int AW    = $clog2(DEPTH)
) (
    // Clock and reset
    input  wire logic               ref_clk,
    input  wire logic               nrst,
    // Host parallel port
    input  wire hdlc_pkg::host_req_t host_req,
    output logic [7:0]              host_rdata,
    output logic                    int_n,
    // Receive HDLC controller
    input  wire logic               rx_bit_valid,
    input  wire logic               rx_bit,
    input  wire logic               rx_byte_valid,
    input  wire hdlc_pkg::rx_byte_t  rx_byte,
    // Transmit HDLC controller
    input  wire logic [AW:0]        tx_fifo_level,
    input  wire logic               tx_msg_done
);
    import hdlc_pkg::*;

    localparam logic [AW:0] HALF = (AW+1)'(DEPTH / 2);
    localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

    logic [AW-1:0]      wr_ptr, rd_ptr;
    logic [AW:0]        rx_count;
    logic               fifo_full, fifo_empty, push, pop, overrun, empty_view;
    fifo_entry_t        wr_entry, head;
    logic [10:0]        head_bits;
    logic [2:0]         ones_cnt;
    logic               abort_pulse;
    msg_state_t         state, next_state;
    logic               in_msg, end_evt, good_end, crc_bad;
    logic [6:0]         ev_set, ev_latch, ev_live, cur_events, ev_copy;
    logic [7:0]         mask;
    logic [7:4]         info_set, info_latch, info_copy;
    logic [7:0]         status_clr, info_clr;
    logic               acc_status_wr, acc_info_wr, acc_mask_wr, acc_fifo_rd;

    // Address match for one host access kind
    function automatic logic hit(input logic strobe, input logic [7:0] addr,
                                 input logic [7:0] target);
        return strobe && (addr == target);
    endfunction

    // Host access decode
    assign acc_status_wr = hit(host_req.wr, host_req.addr, `ADDR_EVENT_STATUS);
    assign acc_mask_wr   = hit(host_req.wr, host_req.addr, `ADDR_EVENT_MASK);
    assign acc_info_wr   = hit(host_req.wr, host_req.addr, `ADDR_RX_INFO);
    assign acc_fifo_rd   = hit(host_req.rd, host_req.addr, `ADDR_RX_FIFO);
    assign status_clr    = acc_status_wr ? host_req.wdata : `ZERO8;
    assign info_clr      = acc_info_wr ? host_req.wdata : `ZERO8;

    // Run of consecutive ones on the receive bit stream
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ones_cnt <= 3'h0;
        end else if (rx_bit_valid) begin
            if (!rx_bit) begin
                ones_cnt <= 3'h0;
            end else if (ones_cnt != `ABORT_ONES) begin
                ones_cnt <= ones_cnt + 3'h1;
            end
        end
    end

    // One pulse per run of seven or more ones
    assign abort_pulse = rx_bit_valid && rx_bit && (ones_cnt == `ONES_PRE);

    // FIFO fill and drain conditions
    assign fifo_full  = (rx_count == FULL);
    assign fifo_empty = (rx_count == '0);
    assign push       = rx_byte_valid && !fifo_full;
    assign overrun    = rx_byte_valid && fifo_full;
    assign pop        = acc_fifo_rd && !fifo_empty;

    // Message tracking for fault and end detection
    always_comb begin
        next_state = state;
        case (state)
            MSG_IDLE: begin
                if (rx_byte_valid && rx_byte.first) begin
                    next_state = overrun ? MSG_FAULT : MSG_BODY;
                end
            end
            MSG_BODY: begin
                if (overrun) begin
                    next_state = MSG_FAULT;
                end
            end
            MSG_FAULT: next_state = MSG_FAULT;
            default:   next_state = MSG_IDLE;
        endcase
        if (abort_pulse || (rx_byte_valid && rx_byte.last)) begin
            next_state = MSG_IDLE;
        end
    end

    // Message state register
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state <= MSG_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Message end and result classification
    assign in_msg   = (state != MSG_IDLE) || (rx_byte_valid && rx_byte.first);
    assign crc_bad  = rx_byte_valid && rx_byte.last && !rx_byte.crc_ok;
    assign good_end = push && rx_byte.last && rx_byte.crc_ok && (state != MSG_FAULT);
    assign end_evt  = (in_msg && abort_pulse) || (rx_byte_valid && rx_byte.last)
                      || overrun;

    // Entry stored with its opening, closing and good marks
    always_comb begin
        wr_entry.first = rx_byte.first;
        wr_entry.last  = rx_byte.last;
        wr_entry.good  = good_end;
        wr_entry.data  = rx_byte.data;
    end

    // FIFO pointers and occupancy
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            wr_ptr   <= '0;
            rd_ptr   <= '0;
            rx_count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                rx_count <= rx_count + 1'b1;
            end else if (pop && !push) begin
                rx_count <= rx_count - 1'b1;
            end
        end
    end

    // Empty level aligned with the registered head entry
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            empty_view <= 1'b1;
        end else begin
            empty_view <= fifo_empty;
        end
    end

    // Receive byte storage
    rx_fifo_mem #(
        .WIDTH ($bits(fifo_entry_t)),
        .DEPTH (DEPTH)
    ) u_mem (
        .ref_clk (ref_clk),
        .wr_en   (push),
        .wr_addr (wr_ptr),
        .wr_data (wr_entry),
        .rd_addr (rd_ptr),
        .rd_data (head_bits)
    );
    assign head = fifo_entry_t'(head_bits);

    // Event sources, latched and live
    always_comb begin
        ev_set               = '0;
        ev_set[`EV_RX_END]   = end_evt;
        ev_set[`EV_RX_START] = rx_byte_valid && rx_byte.first;
        ev_set[`EV_TX_MEND]  = tx_msg_done;
        ev_live              = '0;
        ev_live[`EV_RX_HALF] = (rx_count > HALF);
        ev_live[`EV_RX_NE]   = !fifo_empty;
        ev_live[`EV_TX_HALF] = (tx_fifo_level < HALF);
        ev_live[`EV_TX_NF]   = (tx_fifo_level < FULL);
    end
    assign cur_events = (ev_latch & `EV_LATCHED) | (ev_live & ~`EV_LATCHED);

    // Sticky events, a new event wins over a clear
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ev_latch <= '0;
        end else begin
            ev_latch <= (ev_set | (ev_latch & ~status_clr[6:0])) & `EV_LATCHED;
        end
    end

    // Read copy of events loaded per written one
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ev_copy <= '0;
        end else if (acc_status_wr) begin
            ev_copy <= (cur_events & host_req.wdata[6:0])
                       | (ev_copy & ~host_req.wdata[6:0]);
        end
    end

    // Information flag sources
    always_comb begin
        info_set              = '0;
        info_set[`INF_ABORT]  = abort_pulse;
        info_set[`INF_CRCERR] = crc_bad;
        info_set[`INF_OVR]    = overrun;
        info_set[`INF_VALID]  = good_end;
    end

    // Sticky information flags, set wins over clear
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            info_latch <= '0;
        end else begin
            info_latch <= info_set | (info_latch & ~info_clr[7:4]);
        end
    end

    // Read copy of information flags
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            info_copy <= '0;
        end else if (acc_info_wr) begin
            info_copy <= (info_latch & host_req.wdata[7:4])
                         | (info_copy & ~host_req.wdata[7:4]);
        end
    end

    // Interrupt mask register, top bit kept at zero
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            mask <= `MASK_RESET;
        end else if (acc_mask_wr) begin
            mask <= {1'b0, host_req.wdata[6:0]};
        end
    end

    // Interrupt pin, low while any enabled event is pending
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            int_n <= 1'b1;
        end else begin
            int_n <= ~|(cur_events & mask[6:0]);
        end
    end

    // Registered host read data
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            host_rdata <= `ZERO8;
        end else if (host_req.rd) begin
            case (host_req.addr)
                `ADDR_EVENT_STATUS: host_rdata <= {1'b0, ev_copy};
                `ADDR_EVENT_MASK:   host_rdata <= mask;
                `ADDR_RX_INFO: begin
                    host_rdata <= {info_copy, empty_view,
                                   head.good && !empty_view,
                                   head.last && !empty_view,
                                   head.first && !empty_view};
                end
                `ADDR_RX_FIFO: host_rdata <= empty_view ? `ZERO8 : head.data;
                default:            host_rdata <= `ZERO8;
            endcase
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    sequence s_abort_seen;
        rx_bit_valid && rx_bit && (ones_cnt == `ONES_PRE);
    endsequence

    sequence s_mend_kept;
        tx_msg_done ##1 (!acc_status_wr) [*2];
    endsequence

    pkt_end_set_a: assert property (end_evt |=> cur_events[`EV_RX_END])
        else $error("packet end event not raised");
    pkt_start_set_a: assert property ((rx_byte_valid && rx_byte.first)
        |=> cur_events[`EV_RX_START])
        else $error("packet start event not raised");
    half_full_a: assert property ((push && !pop && rx_count == HALF)
        |=> cur_events[`EV_RX_HALF])
        else $error("half full event missing");
    not_empty_a: assert property (push |=> cur_events[`EV_RX_NE])
        else $error("not empty event missing after store");
    mend_hold_a: assert property (s_mend_kept |-> cur_events[`EV_TX_MEND])
        else $error("message end event lost before clear");
    latch_clear_a: assert property ((acc_status_wr && host_req.wdata[`EV_RX_END] && !end_evt)
        |=> !cur_events[`EV_RX_END])
        else $error("packet end latch not cleared");
    mask_block_a: assert property ((mask[6:0] == '0) |=> int_n)
        else $error("masked event drove interrupt");
    int_assert_a: assert property ((|(cur_events & mask[6:0])) |=> !int_n)
        else $error("interrupt not asserted");
    abort_flag_a: assert property (s_abort_seen |=> info_latch[`INF_ABORT])
        else $error("abort flag not set");
    crc_flag_a: assert property (crc_bad |=> info_latch[`INF_CRCERR])
        else $error("checksum error flag not set");
    overrun_flag_a: assert property (overrun |=> info_latch[`INF_OVR]
        && rx_count == ($past(pop) ? FULL - 1'b1 : FULL))
        else $error("overrun flag not set");
    valid_flag_a: assert property (good_end |=> info_latch[`INF_VALID])
        else $error("valid message flag not set");
    empty_level_a: assert property ((rx_count == '0) [*2] |-> empty_view)
        else $error("empty level wrong");
    fifo_pop_a: assert property ((pop && !push) |=> rx_count == $past(rx_count) - 1'b1)
        else $error("host read did not pop");

endmodule

// File: host_port_model.sv
`timescale 1ns/100ps
`include "hdlc_defines.svh"
module host_port_model (
    // Clock
    input  wire logic           ref_clk,
    // Host parallel port
    output hdlc_pkg::host_req_t host_req
);
    import hdlc_pkg::*;

    // Bus idle until the first access
    initial host_req = '0;

    // One access: raised after a falling edge, held over one rising edge
    task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] data);
        @(negedge ref_clk);
        host_req.wr    = wr;
        host_req.rd    = ~wr;
        host_req.addr  = addr;
        host_req.wdata = (addr == `ADDR_EVENT_STATUS || addr == `ADDR_EVENT_MASK) ?
                         {1'b0, data[6:0]} : data;
        @(negedge ref_clk);
        // Released bus drops both strobes and shows inverted address and data
        host_req.wr    = 1'b0;
        host_req.rd    = 1'b0;
        host_req.addr  = ~addr;
        host_req.wdata = ~host_req.wdata;
    endtask

    // Status poll: mask byte first, then a read of the same register
    task automatic status_read(input logic [7:0] addr, input logic [7:0] mask);
        access(1'b1, addr, mask);
        access(1'b0, addr, 8'h00);
    endtask
endmodule

// File: hdlc_rx_status_and_event_unit_test.sv
`timescale 1ns/100ps
`include "hdlc_defines.svh"
module hdlc_rx_status_and_event_unit_test;
    import hdlc_pkg::*;

    logic       ref_clk       = 1'b0;
    logic       nrst          = 1'b0;
    host_req_t  host_req;
    logic [7:0] host_rdata;
    logic       int_n;
    logic       rx_bit_valid  = 1'b0;
    logic       rx_bit        = 1'b0;
    logic       rx_byte_valid = 1'b0;
    rx_byte_t   rx_byte       = '0;
    logic [6:0] tx_fifo_level = 7'h40;
    logic       tx_msg_done   = 1'b0;
    int         err_count     = 0;
    int         checks_done   = 0;
    int         cycles        = 0;
    integer     seed          = 32'hB139;
    logic [7:0] exp_q[$];
    string      name_q[$];
    logic [7:0] data_q[$];
    logic [6:0] lvls[6]       = '{7'h00, 7'h1F, 7'h20, 7'h3F, 7'h40, 7'h00};

    // Clock, 4 ns period
    initial forever #2 ref_clk = ~ref_clk;

    hdlc_rx_status_and_event_unit uut (
        .ref_clk       (ref_clk),
        .nrst          (nrst),
        .host_req      (host_req),
        .host_rdata    (host_rdata),
        .int_n         (int_n),
        .rx_bit_valid  (rx_bit_valid),
        .rx_bit        (rx_bit),
        .rx_byte_valid (rx_byte_valid),
        .rx_byte       (rx_byte),
        .tx_fifo_level (tx_fifo_level),
        .tx_msg_done   (tx_msg_done)
    );

    host_port_model host (
        .ref_clk  (ref_clk),
        .host_req (host_req)
    );

    // Verdict and end of run
    task automatic test_done();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // Compare one value
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string nm);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Note expected read data, then read
    task automatic rd_exp(input logic [7:0] addr, input logic [7:0] exp, input string nm);
        exp_q.push_back(exp);
        name_q.push_back(nm);
        host.access(1'b0, addr, 8'h00);
    endtask

    // Mask-write then read, after letting pending updates land
    task automatic stat(input logic [7:0] addr, input logic [7:0] mask,
                        input logic [7:0] exp, input string nm);
        repeat (2) @(negedge ref_clk);
        exp_q.push_back(exp);
        name_q.push_back(nm);
        host.status_read(addr, mask);
    endtask

    // Interrupt level once the registered path has settled
    task automatic int_chk(input logic exp);
        repeat (3) @(negedge ref_clk);
        check({7'h00, int_n}, {7'h00, exp}, "int_n");
    endtask

    // One received byte; dropped bytes are not kept for comparison
    task automatic send(input logic first, input logic last, input logic crc);
        logic [7:0] d;
        d = 8'($random(seed));
        if (data_q.size() < 64) data_q.push_back(d);
        @(negedge ref_clk);
        rx_byte_valid = 1'b1;
        rx_byte       = '{first, last, crc, d};
        @(negedge ref_clk);
        rx_byte_valid = 1'b0;
        rx_byte.data  = ~d;
    endtask

    // Run of received line bits
    task automatic bits(input int n, input logic b);
        repeat (n) begin
            @(negedge ref_clk);
            rx_bit_valid = 1'b1;
            rx_bit       = b;
        end
        @(negedge ref_clk);
        rx_bit_valid = 1'b0;
    endtask

    // One message of n bytes, then head tags and data byte by byte
    task automatic run_msg(input int n, input logic crc);
        logic [7:0] info;
        host.access(1'b1, `ADDR_EVENT_MASK, 8'h20);
        rd_exp(`ADDR_EVENT_MASK, 8'h20, "mask");
        for (int i = 0; i < n; i++) send(i == 0, i == n - 1, crc);
        int_chk(1'b0);
        stat(`ADDR_EVENT_STATUS, 8'h7F, 8'h68, "events");
        int_chk(1'b1);
        host.access(1'b1, `ADDR_EVENT_MASK, 8'h00);
        for (int i = 0; i < n; i++) begin
            info = {1'b0, i == 0 && !crc, 1'b0, i == 0 && crc, 1'b0,
                    i == n - 1 && crc, i == n - 1, i == 0};
            stat(`ADDR_RX_INFO, crc ? 8'hF0 : 8'hE0, info, "rx info");
            rd_exp(`ADDR_RX_FIFO, data_q.pop_front(), "fifo data");
        end
        stat(`ADDR_RX_INFO, 8'hF0, 8'h08, "rx info");
    endtask

    // Result watcher: one note taken per read
    initial forever begin
        @(posedge ref_clk);
        if (host_req.rd === 1'b1) begin
            @(negedge ref_clk);
            check(host_rdata, exp_q.pop_front(), name_q.pop_front());
        end
    end

    // Hang guard
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            test_done();
        end
    end

    // Main sequence
    initial begin
        repeat (10) @(negedge ref_clk);
        nrst = 1'b1;
        check({7'h00, int_n}, 8'h01, "int_n reset");
        rd_exp(`ADDR_EVENT_MASK, 8'h00, "mask reset");
        rd_exp(`ADDR_RX_INFO, 8'h08, "rx info reset");
        rd_exp(`ADDR_RX_FIFO, 8'h00, "empty fifo");
        host.access(1'b1, `ADDR_RX_FIFO, 8'h55);
        rd_exp(8'hB5, 8'h00, "unmapped");
        rd_exp(8'hB0, 8'h00, "unmapped");
        host.access(1'b1, `ADDR_EVENT_MASK, 8'hFF);
        rd_exp(`ADDR_EVENT_MASK, 8'h7F, "mask");
        host.access(1'b1, `ADDR_EVENT_MASK, 8'h00);
        // Abort needs seven ones in a row
        bits(6, 1'b1);
        bits(1, 1'b0);
        stat(`ADDR_RX_INFO, 8'hF0, 8'h08, "rx info");
        bits(7, 1'b1);
        bits(1, 1'b0);
        stat(`ADDR_RX_INFO, 8'hF0, 8'h88, "rx info");
        stat(`ADDR_RX_INFO, 8'h70, 8'h88, "rx info");
        stat(`ADDR_RX_INFO, 8'hF0, 8'h08, "rx info");
        // Transmit FIFO levels at both thresholds
        lvls[5] = 7'(($random(seed) & 32'h7FFFFFFF) % 65);
        for (int i = 0; i < 6; i++) begin
            @(negedge ref_clk);
            tx_fifo_level = lvls[i];
            stat(`ADDR_EVENT_STATUS, 8'h7F, {5'h00, lvls[i] < 32, lvls[i] < 64, 1'b0},
                 "events");
            int_chk(1'b1);
        end
        host.access(1'b1, `ADDR_EVENT_MASK, 8'h02);
        @(negedge ref_clk);
        tx_fifo_level = 7'h20;
        int_chk(1'b0);
        tx_fifo_level = 7'h40;
        int_chk(1'b1);
        host.access(1'b1, `ADDR_EVENT_MASK, 8'h01);
        @(negedge ref_clk);
        tx_msg_done = 1'b1;
        @(negedge ref_clk);
        tx_msg_done = 1'b0;
        int_chk(1'b0);
        stat(`ADDR_EVENT_STATUS, 8'h7F, 8'h01, "events");
        int_chk(1'b1);
        stat(`ADDR_EVENT_STATUS, 8'h7F, 8'h00, "events");
        host.access(1'b1, `ADDR_EVENT_MASK, 8'h00);
        // Faulty then good message
        run_msg(2, 1'b0);
        run_msg(3, 1'b1);
        // Fill past midpoint, then past full
        for (int i = 0; i < 32; i++) send(i == 0, 1'b0, 1'b0);
        stat(`ADDR_EVENT_STATUS, 8'h7F, 8'h28, "events");
        send(1'b0, 1'b0, 1'b0);
        stat(`ADDR_EVENT_STATUS, 8'h7F, 8'h18, "events");
        for (int i = 0; i < 32; i++) send(1'b0, 1'b0, 1'b0);
        stat(`ADDR_EVENT_STATUS, 8'h7F, 8'h58, "events");
        stat(`ADDR_RX_INFO, 8'hF0, 8'h21, "rx info");
        while (data_q.size() > 0) rd_exp(`ADDR_RX_FIFO, data_q.pop_front(), "fifo data");
        stat(`ADDR_RX_INFO, 8'hF0, 8'h08, "rx info");
        stat(`ADDR_EVENT_STATUS, 8'h7F, 8'h00, "events");
        repeat (4) @(negedge ref_clk);
        test_done();
    end
endmodule
